// ---- rtl/host_port_consts.svh ----
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
// ************************************************************
// Register offsets
// ************************************************************
`define OFS_CONTROL      2'h0
`define OFS_CMD_DATA     2'h1
`define OFS_INTERRUPT    2'h2
// ************************************************************
// Control bit positions
// ************************************************************
`define CTL_BUS_RESET    4
`define CTL_INT_ACK      5
`define CTL_SOFT_RESET   6
`define CTL_HARD_RESET   7
// ************************************************************
// Status bit positions
// ************************************************************
`define ST_CMD_INVALID   0
`define ST_DATA_READY    2
`define ST_CMD_BUSY      3
`define ST_READY         4
`define ST_INIT_REQ      5
`define ST_DIAG_FAIL     6
`define ST_DIAG_ACTIVE   7
// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_PS    5000
`define BUS_RESET_NS     25000
`define BUS_RESET_CYCLES ((`BUS_RESET_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SOFT_RESET_CYCLES 16
`define DIAG_CYCLES       64
`define STATUS_RESET     8'h00
`endif

// ---- rtl/host_port_pkg.sv ----
package host_port_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SOFT  = 2'b01,
      ST_DIAG  = 2'b10
   } reset_state_t;
endpackage

// ---- rtl/pulse_stretcher.sv ----
`timescale 1ns/1ps
// ************************************************************
// Holds an output high for a fixed count after a start pulse
// ************************************************************
module pulse_stretcher #(
   parameter int COUNT = 5000
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic start,
   output logic      active
);
   localparam int W = $clog2(COUNT + 1);
   logic [W-1:0] count;
   wire          done = (count == W'(1));

   if (COUNT < 1) begin : g_count_check
      $error("COUNT must be at least 1");
   end

   // Restart reloads, so the pulse is always at least COUNT cycles
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count  <= '0;
         active <= 1'b0;
      end else if (start) begin
         count  <= W'(COUNT);
         active <= 1'b1;
      end else if (active) begin
         count  <= count - W'(1);
         active <= !done;
      end
   end
endmodule

// ---- rtl/host_io_port.sv ----
`timescale 1ns/1ps
`include "host_port_consts.svh"
module host_io_port
   import host_port_pkg::*;
#(
   parameter logic [15:0] BASE_ADDR   = 16'h0330,
   parameter int          BUS_RST_CYC = `BUS_RESET_CYCLES,
   parameter int          DIAG_CYC    = `DIAG_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [15:0] io_addr,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  io_rdata,
   output logic             irq,
   output logic             scsi_bus_reset,
   output logic             cmd_valid,
   output logic      [7:0]  cmd_byte,
   output logic             flush_work,
   input  wire logic        cmd_taken,
   input  wire logic        cmd_error,
   input  wire logic        data_load,
   input  wire logic [7:0]  data_byte,
   input  wire logic        int_set,
   input  wire logic [7:0]  int_bits,
   input  wire logic        mbox_init_done,
   input  wire logic        diag_fail_in
);
   localparam int DW = $clog2(DIAG_CYC + 1);
   localparam int SW = $clog2(`SOFT_RESET_CYCLES + 1);

   if (DIAG_CYC < 1) begin : g_diag_check
      $error("DIAG_CYC must be at least 1");
   end
   if (BUS_RST_CYC < 1) begin : g_bus_check
      $error("BUS_RST_CYC must be at least 1");
   end
   // The soft reset count shares the timer sized for diagnostics
   if (DW < SW) begin : g_timer_check
      $error("DIAG_CYC too small for the soft reset count");
   end
   // The window would wrap past the top of the I/O space
   if (BASE_ADDR > 16'hFFFC) begin : g_base_check
      $error("BASE_ADDR leaves no room for three registers");
   end

   // ************************************************************
   // Address decode
   // ************************************************************
   wire [15:0] offset   = io_addr - BASE_ADDR;
   wire        in_range = (io_addr >= BASE_ADDR) && (offset < 16'h0003);
   wire [1:0]  reg_sel  = offset[1:0];
   wire        wr_ctl   = io_wr && in_range && (reg_sel == `OFS_CONTROL);
   wire        wr_cmd   = io_wr && in_range && (reg_sel == `OFS_CMD_DATA);
   wire        rd_data  = io_rd && in_range && (reg_sel == `OFS_CMD_DATA);
   // no write strobe for offset two
   wire        rd_any   = io_rd && in_range;

   wire        req_hard = wr_ctl && io_wdata[`CTL_HARD_RESET];
   wire        req_soft = wr_ctl && io_wdata[`CTL_SOFT_RESET] && !req_hard;
   wire        req_bus  = wr_ctl && io_wdata[`CTL_BUS_RESET];
   wire        req_ack  = wr_ctl && io_wdata[`CTL_INT_ACK];

   // ************************************************************
   // Internal state
   // ************************************************************
   reset_state_t    state;
   reset_state_t    next_state;
   logic [DW-1:0]   timer;
   logic [DW-1:0]   next_timer;
   logic            ready;
   logic            init_req;
   logic            diag_active;
   logic            diag_fail;
   logic            data_ready;
   logic            cmd_busy;
   logic            cmd_invalid;
   logic [7:0]      data_reg;
   logic [7:0]      int_reg;
   logic            bus_rst_active;

   wire busy_reset = (state != ST_IDLE);
   wire timer_done = (timer == DW'(0));
   wire finishing  = busy_reset && timer_done;

   // the bus bit or a hard reset starts it, soft reset does not
   pulse_stretcher #(
      .COUNT (BUS_RST_CYC)
   ) u_bus_reset (
      .clk_sys (clk_sys),
      .rst     (rst),
      .start   (req_bus || req_hard),
      .active  (bus_rst_active)
   );

   // ************************************************************
   // Reset sequencer
   // ************************************************************
   // sequencer entry; bits self-clear as no bit is stored
   always_comb begin
      next_state = state;
      next_timer = timer;
      if (req_hard) begin
         next_state = ST_DIAG;
         next_timer = DW'(DIAG_CYC - 1);
      end else if (req_soft && state != ST_DIAG) begin
         next_state = ST_SOFT;
         next_timer = DW'(`SOFT_RESET_CYCLES - 1);
      end else if (finishing) begin
         next_state = ST_IDLE;
      end else if (busy_reset) begin
         next_timer = timer - DW'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= ST_DIAG;
         timer <= DW'(DIAG_CYC - 1);
      end else begin
         state <= next_state;
         timer <= next_timer;
      end
   end

   // ************************************************************
   // Status flags
   // ************************************************************
   // ready, init and diagnostic flags
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ready       <= 1'b0;
         init_req    <= 1'b0;
         diag_active <= 1'b1;
         diag_fail   <= 1'b0;
      end else if (req_hard) begin
         ready       <= 1'b0;
         init_req    <= 1'b0;
         diag_active <= 1'b1;
         diag_fail   <= 1'b0;
      end else if (req_soft && state != ST_DIAG) begin
         ready    <= 1'b0;
         init_req <= 1'b0;
      end else if (finishing) begin
         ready       <= 1'b1;
         init_req    <= !(state == ST_DIAG && diag_fail_in);
         diag_active <= (state == ST_DIAG) ? diag_fail_in : diag_active;
         diag_fail   <= (state == ST_DIAG) ? diag_fail_in : diag_fail;
      end else if (mbox_init_done) begin
         init_req <= 1'b0;
      end
   end

   // ************************************************************
   // Command and data handshake
   // ************************************************************
   // Hardware set wins over host-side clear, except data_ready while a reset sequence runs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmd_busy    <= 1'b0;
         cmd_byte    <= 8'h00;
         cmd_invalid <= 1'b0;
         data_ready  <= 1'b0;
         data_reg    <= 8'h00;
      end else begin
         if (wr_cmd && !busy_reset) begin
            cmd_busy <= 1'b1;
            cmd_byte <= io_wdata;
         end else if (cmd_taken || busy_reset) begin
            cmd_busy <= 1'b0;
         end
         if (cmd_error) cmd_invalid <= 1'b1;
         else if (wr_cmd || busy_reset) cmd_invalid <= 1'b0;
         if (data_load && !busy_reset) begin
            data_ready <= 1'b1;
            data_reg   <= data_byte;
         end else if (rd_data || busy_reset) begin
            data_ready <= 1'b0;
         end
      end
   end

   // acknowledge clears flags, new event wins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         int_reg <= 8'h00;
      end else if (int_set) begin
         int_reg <= (req_ack ? 8'h00 : int_reg) | int_bits;
      end else if (req_ack || busy_reset) begin
         int_reg <= 8'h00;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   wire [7:0] status_word = {diag_active, diag_fail, init_req, ready,
                             cmd_busy, data_ready, 1'b0, cmd_invalid};
   wire [7:0] read_mux = (reg_sel == `OFS_CONTROL)  ? status_word :
                         (reg_sel == `OFS_CMD_DATA) ? data_reg    : int_reg;
   wire       next_irq = int_set | ((int_reg != 8'h00) & !req_ack & !busy_reset);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         io_rdata       <= `STATUS_RESET;
         irq            <= 1'b0;
         scsi_bus_reset <= 1'b0;
         cmd_valid      <= 1'b0;
         flush_work     <= 1'b0;
      end else begin
         io_rdata       <= rd_any ? read_mux : 8'h00;
         irq            <= next_irq;
         scsi_bus_reset <= bus_rst_active;
         cmd_valid      <= cmd_busy && !busy_reset;
         flush_work     <= busy_reset || req_hard || req_soft;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   logic hard_seen;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) hard_seen <= 1'b0;
      else hard_seen <= req_hard;
   end

   // Length of the current bus reset drive, in cycles
   logic [31:0] bus_run;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) bus_run <= 32'h00000000;
      else if (scsi_bus_reset) bus_run <= bus_run + 32'h00000001;
      else bus_run <= 32'h00000000;
   end

   property p_bus_reset_start;
      @(posedge clk_sys) disable iff (rst) req_bus |-> ##2 scsi_bus_reset;
   endproperty
   a_bus_reset_start: assert property (p_bus_reset_start) else $error("bus reset not driven");

   property p_bus_reset_hold;
      @(posedge clk_sys) disable iff (rst) req_bus |-> ##2 scsi_bus_reset [*8];
   endproperty
   a_bus_reset_hold: assert property (p_bus_reset_hold) else $error("bus reset too short");

   property p_soft_no_bus;
      @(posedge clk_sys) disable iff (rst)
         (req_soft && !req_bus && !scsi_bus_reset && !bus_rst_active) |=> !bus_rst_active;
   endproperty
   a_soft_no_bus: assert property (p_soft_no_bus) else $error("soft reset drove bus reset");

   property p_ack_clears;
      @(posedge clk_sys) disable iff (rst) (req_ack && !int_set) |=> (int_reg == 8'h00) && !irq;
   endproperty
   a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

   property p_diag_active;
      @(posedge clk_sys) disable iff (rst) (hard_seen || state == ST_DIAG) |-> diag_active && !ready;
   endproperty
   a_diag_active: assert property (p_diag_active) else $error("diag flag missing");

   property p_finish_flags;
      @(posedge clk_sys) disable iff (rst)
         (finishing && state == ST_SOFT && !req_hard && !req_soft) |=> ready && init_req;
   endproperty
   a_finish_flags: assert property (p_finish_flags) else $error("ready/init not set");

   property p_hard_over_soft;
      @(posedge clk_sys) disable iff (rst) req_hard |=> state == ST_DIAG;
   endproperty
   a_hard_over_soft: assert property (p_hard_over_soft) else $error("hard reset lost");

   property p_no_write_two;
      @(posedge clk_sys) disable iff (rst)
         (io_wr && in_range && reg_sel == `OFS_INTERRUPT && !int_set && !busy_reset && !data_load)
         |=> $stable(int_reg) && $stable(data_reg);
   endproperty
   a_no_write_two: assert property (p_no_write_two) else $error("offset two write changed state");

   property p_status_read;
      @(posedge clk_sys) disable iff (rst)
         (io_rd && in_range && reg_sel == `OFS_CONTROL) |=> io_rdata[`ST_READY] == $past(ready);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_bus_reset_len;
      @(posedge clk_sys) disable iff (rst) $fell(scsi_bus_reset) |-> bus_run >= BUS_RST_CYC;
   endproperty
   a_bus_reset_len: assert property (p_bus_reset_len) else $error("bus reset shorter than minimum");

   property p_init_clear;
      @(posedge clk_sys) disable iff (rst)
         (mbox_init_done && !finishing && !req_hard && !req_soft) |=> !init_req;
   endproperty
   a_init_clear: assert property (p_init_clear) else $error("init flag not cleared");

   c_bus_reset: cover property (@(posedge clk_sys) disable iff (rst) req_bus);
   c_soft:      cover property (@(posedge clk_sys) disable iff (rst) req_soft ##[1:40] finishing);
   c_ack:       cover property (@(posedge clk_sys) disable iff (rst) irq ##1 req_ack);
endmodule

// ---- sim/host_cpu_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Host processor doing byte I/O cycles
// ****************************************
module host_cpu_model #(
   parameter logic [15:0] BASE_ADDR = 16'h0330
) (
   input  wire logic        clk_sys,
   output logic      [15:0] io_addr,
   output logic             io_wr,
   output logic             io_rd,
   output logic      [7:0]  io_wdata,
   input  wire logic [7:0]  io_rdata
);
   initial begin
      io_addr  = 16'h0000;
      io_wr    = 1'b0;
      io_rd    = 1'b0;
      io_wdata = 8'h00;
   end

   task automatic write_reg(input logic [1:0] ofs, input logic [7:0] data);
      @(negedge clk_sys);
      io_addr  = BASE_ADDR + {14'h0000, ofs};
      io_wdata = (ofs == 2'h0) ? {data[7:4], 4'h0} : data;
      io_wr    = 1'b1;
      @(negedge clk_sys);
      io_wr    = 1'b0;
      // Released lines show garbage, not the old value
      io_addr  = ~io_addr;
      io_wdata = ~io_wdata;
   endtask

   task automatic read_reg(input logic [1:0] ofs, output logic [7:0] data);
      @(negedge clk_sys);
      io_addr = BASE_ADDR + {14'h0000, ofs};
      io_rd   = 1'b1;
      @(negedge clk_sys);
      io_rd   = 1'b0;
      data    = io_rdata;
      io_addr = ~io_addr;
   endtask
endmodule

// ---- sim/scsi_adapter_host_io_port_bench.sv ----
`timescale 1ns/1ps
module scsi_adapter_host_io_port_bench;
   localparam int BUS_CYC = 20;
   localparam int DIAG    = 64;
   logic        clk_sys, rst, io_wr, io_rd, irq, scsi_bus_reset, cmd_valid, flush_work;
   logic        cmd_taken, cmd_error, data_load, int_set, mbox_init_done, diag_fail_in;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata, io_rdata, cmd_byte, data_byte, int_bits, rd;
   int          fails, compares, cycles, bus_hi, flush_hi;

   host_io_port #(.BUS_RST_CYC(BUS_CYC), .DIAG_CYC(DIAG)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .irq(irq), .scsi_bus_reset(scsi_bus_reset),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .flush_work(flush_work),
      .cmd_taken(cmd_taken), .cmd_error(cmd_error), .data_load(data_load),
      .data_byte(data_byte), .int_set(int_set), .int_bits(int_bits),
      .mbox_init_done(mbox_init_done), .diag_fail_in(diag_fail_in));

   host_cpu_model host_u (
      .clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata));

   // ****************************************
   // Clock, watchdog and pin monitors
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (scsi_bus_reset === 1'b1) bus_hi++;
      if (flush_work === 1'b1) flush_hi++;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic summarize();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [1:0] ofs, input logic [7:0] exp);
      host_u.read_reg(ofs, rd);
      check(rd, exp);
   endtask

   // Bounded poll; busy intervals are only tens of cycles
   task automatic wait_status(input logic [7:0] exp);
      int i;
      for (i = 0; i < 100; i++) begin
         host_u.read_reg(2'h0, rd);
         if (rd === exp) break;
      end
      check(rd, exp);
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      {cmd_taken, cmd_error, data_load, int_set, mbox_init_done, diag_fail_in} = 6'h00;
      {data_byte, int_bits} = 16'h0000;
      repeat (20) @(posedge clk_sys);
      @(negedge clk_sys) rst = 1'b0;
      rd_chk(2'h0, 8'h80);
      wait_status(8'h30);
      rd_chk(2'h3, 8'h00);
      @(negedge clk_sys) cmd_error = 1'b1;
      @(negedge clk_sys) cmd_error = 1'b0;
      rd_chk(2'h0, 8'h31);
      host_u.write_reg(2'h1, 8'hA5);
      // The valid flag trails the busy bit by one register
      @(negedge clk_sys);
      check({7'h00, cmd_valid}, 8'h01);
      check(cmd_byte, 8'hA5);
      rd_chk(2'h0, 8'h38);
      @(negedge clk_sys) cmd_taken = 1'b1;
      @(negedge clk_sys) cmd_taken = 1'b0;
      rd_chk(2'h0, 8'h30);
      data_byte = 8'h5C;
      @(negedge clk_sys) data_load = 1'b1;
      @(negedge clk_sys) data_load = 1'b0;
      rd_chk(2'h0, 8'h34);
      rd_chk(2'h1, 8'h5C);
      rd_chk(2'h0, 8'h30);
      int_bits = 8'h81;
      @(negedge clk_sys) int_set = 1'b1;
      @(negedge clk_sys) int_set = 1'b0;
      host_u.write_reg(2'h2, 8'hFF);
      rd_chk(2'h2, 8'h81);
      check({7'h00, irq}, 8'h01);
      host_u.write_reg(2'h0, 8'h20);
      rd_chk(2'h2, 8'h00);
      check({7'h00, irq}, 8'h00);
      bus_hi = 0;
      host_u.write_reg(2'h0, 8'h10);
      repeat (BUS_CYC + 10) @(negedge clk_sys);
      check(8'(bus_hi), 8'(BUS_CYC));
      rd_chk(2'h0, 8'h30);
      // Software reinitialises the mailboxes after reset
      @(negedge clk_sys) mbox_init_done = 1'b1;
      @(negedge clk_sys) mbox_init_done = 1'b0;
      rd_chk(2'h0, 8'h10);
      bus_hi   = 0;
      flush_hi = 0;
      host_u.write_reg(2'h0, 8'h40);
      wait_status(8'h30);
      check(8'(bus_hi), 8'h00);
      check({7'h00, flush_hi != 0}, 8'h01);
      // Old pointers are dropped here; a fresh init clears the flag
      @(negedge clk_sys) mbox_init_done = 1'b1;
      @(negedge clk_sys) mbox_init_done = 1'b0;
      rd_chk(2'h0, 8'h10);
      // Failing self-test leaves the active flag standing
      diag_fail_in = 1'b1;
      bus_hi = 0;
      host_u.write_reg(2'h0, 8'hC0);
      rd_chk(2'h0, 8'h80);
      repeat (DIAG + 20) @(negedge clk_sys);
      // Ready still rises, init-required stays low after a failed test
      rd_chk(2'h0, 8'hD0);
      check(8'(bus_hi), 8'(BUS_CYC));
      diag_fail_in = 1'b0;
      host_u.write_reg(2'h0, 8'h80);
      wait_status(8'h30);
      summarize();
   end
endmodule
